// [rtl/iwc_regs.svh]
// register offsets, field positions, reset values and timing counts
// assumes a 40 MHz system clock and an 8-bit byte address on the bus
`ifndef IWC_REGS_SVH
`define IWC_REGS_SVH
`define IWC_ADDR_W 8
`define IWC_ADDR_CFG 8'hc8
`define IWC_ADDR_STATUS 8'hcc
`define IWC_CFG_RESET 8'h00
`define IWC_CFG_SRC1_LEVEL 6
`define IWC_CFG_SRC2_RISING 5
`define IWC_CFG_GEN 4
`define IWC_ST_REQ_LSB 0
`define IWC_ST_PWR_LSB 8
`define IWC_RESP_OKAY 2'b00
`define IWC_RESP_SLVERR 2'b10
`define IWC_CLK_NS 25
`define IWC_OSC_STAB_NS 1000
`define IWC_OSC_STAB_CYCLES ((`IWC_OSC_STAB_NS + `IWC_CLK_NS - 1) / `IWC_CLK_NS)
`endif

// [rtl/iwc_pkg.sv]
// types shared by the interrupt and wake control block
// assumes iwc_regs.svh for all numeric constants
package iwc_pkg;
  typedef enum logic [2:0] {
    IWC_MODE_NORMAL = 3'b001,
    IWC_MODE_IRQ = 3'b010,
    IWC_MODE_NMI = 3'b100
  } iwc_mode_t;
  typedef enum logic [3:0] {
    IWC_PWR_RUN = 4'b0001,
    IWC_PWR_WAIT = 4'b0010,
    IWC_PWR_STOP = 4'b0100,
    IWC_PWR_STAB = 4'b1000
  } iwc_pwr_t;
  typedef struct packed {
    logic src1_level;
    logic src2_rising;
    logic gen;
  } iwc_cfg_t;
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] opt;
    logic [7:0] data;
  } iwc_port_cfg_t;
  typedef struct packed {
    logic timer_zero_flag;
    logic timer_irq_mask;
    logic converter_eoc_flag;
    logic converter_irq_mask;
    logic reload_overflow_flag;
    logic reload_overflow_irq_mask;
    logic reload_compare_flag;
    logic reload_compare_irq_mask;
    logic reload_edge_flag;
    logic reload_edge_irq_mask;
    logic serial_running_flag;
    logic serial_irq_mask;
  } iwc_periph_t;
endpackage

// [rtl/iwc_top.sv]
// interrupt option register, vector request mapping and wait/stop control
// assumes core, peripherals and port registers run on clk_sys; pins are async
`timescale 1ns/1ps
`include "iwc_regs.svh"

// Function
// - config byte is write-only, reset to zero, written only as a whole byte
// - bit 6 set makes source 1 level sensitive, clear makes it edge
// - bit 5 picks the edge polarity of source 2, always edge sensitive
// - polarity bit one means rising edges, zero means falling edges
// - bit 4 global enable blocks all maskable requests, never the non-maskable
// - with global enable low nothing wakes the device, only reset
// - vector 4 carries timer overflow and converter end, each masked
// - vector 3 carries reload overflow, compare and input edge, each masked
// - vector 2 carries serial end of transmission under its mask
// - a pin interrupts only as input with direction 0, option 1, data 0
// - an edge sets a latch cleared at routine start; repeats stored once
// - wait halts the core but keeps clock and peripherals running
// - wake from wait resumes at once, no stabilisation delay
// - stop halts oscillator; only external request or reset ends it
// - wake from stop waits for oscillator stabilisation before resuming
// - reset during wait or stop runs the normal reset sequence
// - from main routine a wake services the interrupt, then continues
// - from non-maskable routine a wake continues without servicing
// - from maskable routine a maskable wake continues the routine
// - from maskable routine a non-maskable wake services it first
// - with watchdog active a stop command behaves as wait
// - wait or stop is skipped while an enabled request is pending
// - interrupts and wakes leave the oscillator selection untouched
module iwc_top import iwc_pkg::*; #(
  parameter int unsigned STAB_CYCLES = `IWC_OSC_STAB_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [`IWC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`IWC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins, asynchronous
  input wire logic [7:0] port_a_pin,
  input wire logic [7:0] port_b_pin,
  input wire logic [7:0] port_c_pin,
  input wire logic nmi_pin_n,
  // port configuration and peripheral events
  input wire iwc_port_cfg_t port_a_cfg,
  input wire iwc_port_cfg_t port_b_cfg,
  input wire iwc_port_cfg_t port_c_cfg,
  input wire iwc_periph_t periph,
  input wire logic watchdog_active,
  // core side
  input wire iwc_mode_t core_mode,
  input wire logic core_ack,
  input wire logic [2:0] core_ack_vec,
  input wire logic cmd_wait,
  input wire logic cmd_stop,
  output logic [4:0] irq_req,
  output logic core_halt,
  output logic osc_stop,
  output logic wake_pulse,
  output logic wake_service,
  output logic skip_pulse
);

  // the wake delay counter is 12 bits wide
  if (STAB_CYCLES < 1 || STAB_CYCLES > 4095) begin
    $error("STAB_CYCLES out of range");
  end


  // ----------------------------------------
  // option register and bus slave
  // ----------------------------------------
  iwc_cfg_t cfg_reg;
  logic aw_have_reg, w_have_reg;
  logic [`IWC_ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_byte_reg;
  logic w_full_reg;
  logic aw_take, w_take, ar_take, do_write, aw_have_next, w_have_next;
  iwc_pwr_t pwr_reg;
  logic [4:0] req_next;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign aw_have_next = (aw_have_reg | aw_take) & ~do_write;
  assign w_have_next = (w_have_reg | w_take) & ~do_write;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_addr_reg <= '0;
      w_byte_reg <= 8'h00;
      w_full_reg <= 1'b0;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      s_axi_awready <= ~aw_have_next;
      s_axi_wready <= ~w_have_next;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_byte_reg <= s_axi_wdata[7:0];
        w_full_reg <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IWC_RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `IWC_RESP_OKAY;
        if (aw_addr_reg == `IWC_ADDR_CFG) begin
          // a lane-0 strobe is needed: no partial update of the byte
          if (w_full_reg) begin
            cfg_reg.src1_level <= w_byte_reg[`IWC_CFG_SRC1_LEVEL];
            cfg_reg.src2_rising <= w_byte_reg[`IWC_CFG_SRC2_RISING];
            cfg_reg.gen <= w_byte_reg[`IWC_CFG_GEN];
          end
        end else if (aw_addr_reg != `IWC_ADDR_STATUS) begin
          s_axi_bresp <= `IWC_RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IWC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `IWC_RESP_OKAY;
        // option byte is write-only and reads as zero
        if (s_axi_araddr == `IWC_ADDR_STATUS) begin
          s_axi_rdata[`IWC_ST_REQ_LSB +: 5] <= irq_req;
          s_axi_rdata[`IWC_ST_PWR_LSB +: 4] <= pwr_reg;
        end else if (s_axi_araddr != `IWC_ADDR_CFG) begin
          s_axi_rresp <= `IWC_RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------
  logic [24:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic [7:0] pa, pb, pc, pa_prev, pb_prev, pc_prev;
  logic [7:0] en_a, en_b, en_c;
  logic nmi_n, nmi_n_prev;
  logic src1_low, src1_fall, src2_edge, nmi_fall;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= {25{1'b1}};
      pin_sync_reg <= {25{1'b1}};
      pin_prev_reg <= {25{1'b1}};
    end else begin
      pin_meta_reg <= {nmi_pin_n, port_c_pin, port_b_pin, port_a_pin};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  assign {nmi_n, pc, pb, pa} = pin_sync_reg;
  assign {nmi_n_prev, pc_prev, pb_prev, pa_prev} = pin_prev_reg;
  assign en_a = ~port_a_cfg.dir & port_a_cfg.opt & ~port_a_cfg.data;
  assign en_b = ~port_b_cfg.dir & port_b_cfg.opt & ~port_b_cfg.data;
  assign en_c = ~port_c_cfg.dir & port_c_cfg.opt & ~port_c_cfg.data;
  assign src1_low = |(en_a & ~pa) | |(en_b & ~pb);
  assign src1_fall = |(en_a & ~pa & pa_prev) | |(en_b & ~pb & pb_prev);
  // per-pin edges so a polarity change cannot fake an edge
  assign src2_edge = cfg_reg.src2_rising ? |(en_c & pc & ~pc_prev)
                                         : |(en_c & ~pc & pc_prev);
  assign nmi_fall = ~nmi_n & nmi_n_prev;

  // ----------------------------------------
  // request latches and vector mapping
  // ----------------------------------------
  logic latch1_reg, latch2_reg, nmi_latch_reg;
  logic [4:1] raw;
  logic pend_any, wake_any, wake_ext;

  // set beats clear in the same cycle so no edge is lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      latch1_reg <= 1'b0;
      latch2_reg <= 1'b0;
      nmi_latch_reg <= 1'b0;
    end else begin
      if (src1_fall && !cfg_reg.src1_level) begin
        latch1_reg <= 1'b1;
      end else if (core_ack && core_ack_vec == 3'h1) begin
        latch1_reg <= 1'b0;
      end
      if (src2_edge) begin
        latch2_reg <= 1'b1;
      end else if (core_ack && core_ack_vec == 3'h2) begin
        latch2_reg <= 1'b0;
      end
      if (nmi_fall) begin
        nmi_latch_reg <= 1'b1;
      end else if (core_ack && core_ack_vec == 3'h0) begin
        nmi_latch_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    raw[1] = cfg_reg.src1_level ? src1_low : latch1_reg;
    raw[2] = latch2_reg | (periph.serial_running_flag & periph.serial_irq_mask);
    raw[3] = (periph.reload_overflow_flag & periph.reload_overflow_irq_mask)
      | (periph.reload_compare_flag & periph.reload_compare_irq_mask)
      | (periph.reload_edge_flag & periph.reload_edge_irq_mask);
    raw[4] = (periph.timer_zero_flag & periph.timer_irq_mask)
      | (periph.converter_eoc_flag & periph.converter_irq_mask);
    req_next = {raw & {4{cfg_reg.gen}}, nmi_latch_reg};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 5'h00;
    end else begin
      irq_req <= req_next;
    end
  end

  assign pend_any = |req_next;
  // global enable low removes every wake source, the nmi included
  assign wake_any = cfg_reg.gen & (|raw | nmi_latch_reg);
  assign wake_ext = cfg_reg.gen & (raw[1] | latch2_reg | nmi_latch_reg);

  // ----------------------------------------
  // wait / stop power control
  // ----------------------------------------
  logic [11:0] stab_cnt_reg;
  logic wake_nmi_reg;
  logic lp_cmd;

  assign lp_cmd = cmd_wait | cmd_stop;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= IWC_PWR_RUN;
      stab_cnt_reg <= 12'h000;
      wake_nmi_reg <= 1'b0;
    end else begin
      unique case (pwr_reg)
        IWC_PWR_RUN: begin
          if (lp_cmd && !pend_any) begin
            if (cmd_stop && !watchdog_active) begin
              pwr_reg <= IWC_PWR_STOP;
            end else begin
              pwr_reg <= IWC_PWR_WAIT;
            end
          end
        end
        IWC_PWR_WAIT: begin
          if (wake_any) begin
            pwr_reg <= IWC_PWR_RUN;
          end
        end
        IWC_PWR_STOP: begin
          if (wake_ext) begin
            pwr_reg <= IWC_PWR_STAB;
            stab_cnt_reg <= 12'(STAB_CYCLES - 1);
            wake_nmi_reg <= nmi_latch_reg;
          end
        end
        IWC_PWR_STAB: begin
          if (stab_cnt_reg == 12'h000) begin
            pwr_reg <= IWC_PWR_RUN;
          end else begin
            stab_cnt_reg <= stab_cnt_reg - 12'h001;
          end
        end
      endcase
    end
  end

  logic resume_now, resume_nmi;
  assign resume_now = (pwr_reg == IWC_PWR_WAIT && wake_any)
    || (pwr_reg == IWC_PWR_STAB && stab_cnt_reg == 12'h000);
  assign resume_nmi = (pwr_reg == IWC_PWR_WAIT) ? nmi_latch_reg : wake_nmi_reg;

  // oscillator selection is never touched here, only its run/stop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_halt <= 1'b0;
      osc_stop <= 1'b0;
      wake_pulse <= 1'b0;
      wake_service <= 1'b0;
      skip_pulse <= 1'b0;
    end else begin
      wake_pulse <= resume_now;
      skip_pulse <= (pwr_reg == IWC_PWR_RUN) && lp_cmd && pend_any;
      if (pwr_reg == IWC_PWR_RUN && lp_cmd && !pend_any) begin
        core_halt <= 1'b1;
        osc_stop <= cmd_stop && !watchdog_active;
      end else if (pwr_reg == IWC_PWR_STOP && wake_ext) begin
        osc_stop <= 1'b0;
      end else if (resume_now) begin
        core_halt <= 1'b0;
      end
      if (resume_now) begin
        unique case (core_mode)
          IWC_MODE_NORMAL: wake_service <= 1'b1;
          IWC_MODE_NMI: wake_service <= 1'b0;
          IWC_MODE_IRQ: wake_service <= resume_nmi;
          default: wake_service <= 1'b0;
        endcase
      end else begin
        wake_service <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_cfg_write_lands: assert property (
    do_write && aw_addr_reg == `IWC_ADDR_CFG && w_full_reg
    |=> cfg_reg.gen == $past(w_byte_reg[`IWC_CFG_GEN])
        && cfg_reg.src1_level == $past(w_byte_reg[`IWC_CFG_SRC1_LEVEL]))
    else $error("option byte write not taken");
  a_gen_blocks: assert property (
    !cfg_reg.gen |=> irq_req[4:1] == 4'h0)
    else $error("maskable request passed with enable low");
  a_gen_no_wake: assert property (
    (pwr_reg == IWC_PWR_WAIT || pwr_reg == IWC_PWR_STOP) && !cfg_reg.gen
    |=> pwr_reg == $past(pwr_reg) && !wake_pulse)
    else $error("woke with enable low");
  a_wait_fast: assert property (
    pwr_reg == IWC_PWR_WAIT && wake_any |=> pwr_reg == IWC_PWR_RUN && wake_pulse)
    else $error("wait wake delayed");
  a_stop_stab: assert property (
    pwr_reg == IWC_PWR_STOP && wake_ext
    |=> pwr_reg == IWC_PWR_STAB && stab_cnt_reg == 12'(STAB_CYCLES - 1) && !wake_pulse)
    else $error("stop wake skipped stabilisation");
  a_skip_pend: assert property (
    pwr_reg == IWC_PWR_RUN && lp_cmd && pend_any |=> pwr_reg == IWC_PWR_RUN ##0 skip_pulse)
    else $error("low power entered with request pending");
  a_wdog_wait: assert property (
    pwr_reg == IWC_PWR_RUN && cmd_stop && watchdog_active && !pend_any
    |=> pwr_reg == IWC_PWR_WAIT && !osc_stop)
    else $error("stop taken with watchdog active");
  a_edge_held: assert property (
    src2_edge |=> latch2_reg)
    else $error("source 2 edge not latched");
  a_nmi_cont: assert property (
    resume_now && core_mode == IWC_MODE_NMI |=> wake_pulse && !wake_service)
    else $error("serviced a wake in nmi mode");

  c_wait_wake: cover property (pwr_reg == IWC_PWR_WAIT ##1 wake_pulse);
  c_stop_wake: cover property (pwr_reg == IWC_PWR_STAB ##1 wake_pulse);
  c_skip: cover property (skip_pulse);
endmodule

// [verif/iwc_core_model.sv]
// core stand-in for the interrupt and wake block: starts routines on request
// assumes one clk_sys domain; the bench opens and closes the ack window
`timescale 1ns/1ps
module iwc_core_model import iwc_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // block side
  input wire logic [4:0] irq_req,
  input wire logic core_halt,
  // bench control, slow answers come from holding this low
  input wire logic ack_en,
  // routine start
  output logic core_ack,
  output logic [2:0] core_ack_vec
);
  // ---------------------------------
  // routine start
  // ---------------------------------
  // one start every other cycle at most, top priority first, never while frozen
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_ack <= 1'b0;
      core_ack_vec <= 3'h0;
    end else begin
      core_ack <= 1'b0;
      if (ack_en && !core_halt && !core_ack && (irq_req != 5'h00)) begin
        core_ack <= 1'b1;
        for (int i = 4; i >= 0; i--) begin
          if (irq_req[i]) begin
            core_ack_vec <= 3'(i);
          end
        end
      end
    end
  end
endmodule

// [verif/interrupt_wake_control_test.sv]
// self-checking bench for the interrupt and wake control block
// assumes iwc_core_model as core stand-in and a 40 MHz clk_sys
`timescale 1ns/1ps
`include "iwc_regs.svh"
module interrupt_wake_control_test import iwc_pkg::*;;
  // ---------------------------------
  // signals
  // ---------------------------------
  // short stabilisation keeps the stop cases quick
  localparam int STAB = 8;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] port_a_pin = 8'hff;
  logic [7:0] port_b_pin = 8'hff;
  logic [7:0] port_c_pin = 8'hff;
  logic nmi_pin_n = 1'b1;
  iwc_port_cfg_t port_a_cfg = 24'h000100;
  iwc_port_cfg_t port_b_cfg = 24'h000200;
  iwc_port_cfg_t port_c_cfg = 24'h000400;
  iwc_periph_t periph = 12'h000;
  iwc_mode_t core_mode = IWC_MODE_NORMAL;
  logic watchdog_active = 1'b0;
  logic cmd_wait = 1'b0;
  logic cmd_stop = 1'b0;
  logic ack_en = 1'b0;
  logic core_ack;
  logic [2:0] core_ack_vec;
  logic [4:0] irq_req;
  logic core_halt, osc_stop, wake_pulse, wake_service, skip_pulse;
  int errors = 0;
  int checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  iwc_top #(.STAB_CYCLES(STAB)) dut_u (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_pin, .port_b_pin,
    .port_c_pin, .nmi_pin_n, .port_a_cfg, .port_b_cfg, .port_c_cfg, .periph,
    .watchdog_active, .core_mode, .core_ack, .core_ack_vec, .cmd_wait, .cmd_stop,
    .irq_req, .core_halt, .osc_stop, .wake_pulse, .wake_service, .skip_pulse);

  iwc_core_model core_u (.clk_sys, .rst_n, .irq_req, .core_halt, .ack_en, .core_ack,
    .core_ack_vec);

  // ---------------------------------
  // shared tasks
  // ---------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // waits for the answer as long as it takes; only the watchdog ends a hang
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [1:0] resp);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic cfg(input logic [7:0] v);
    logic [1:0] r;
    axi_wr(`IWC_ADDR_CFG, {24'h0, v}, 4'hf, r);
    check("cfg bresp", `IWC_RESP_OKAY, r);
  endtask
  task automatic status(input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(`IWC_ADDR_STATUS, d, r);
    check(what, exp, d);
  endtask
  task automatic set_periph(input logic [11:0] v);
    @(posedge clk_sys);
    periph <= v;
  endtask
  task automatic pins(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
      input logic n);
    @(posedge clk_sys);
    port_a_pin <= a;
    port_b_pin <= b;
    port_c_pin <= c;
    nmi_pin_n <= n;
  endtask
  task automatic ack;
    @(posedge clk_sys);
    ack_en <= 1'b1;
    tick(6);
    @(posedge clk_sys);
    ack_en <= 1'b0;
    tick(1);
  endtask
  task automatic cmd(input logic stop);
    @(posedge clk_sys);
    cmd_stop <= stop;
    cmd_wait <= !stop;
    @(posedge clk_sys);
    cmd_stop <= 1'b0;
    cmd_wait <= 1'b0;
    #1;
  endtask
  task automatic wait_pulse(input logic skip, output int n);
    n = 0;
    while ((skip ? skip_pulse : wake_pulse) !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
  endtask

  // ---------------------------------
  // scenarios
  // ---------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(`IWC_ADDR_CFG, d, r);
    check("cfg read", 32'h0, d);
    status(32'h100, "status reset");
    axi_rd(8'h40, d, r);
    check("unmapped rresp", `IWC_RESP_SLVERR, r);
    axi_wr(8'h40, 32'h10, 4'hf, r);
    check("unmapped bresp", `IWC_RESP_SLVERR, r);
    set_periph(12'hc00);
    axi_wr(`IWC_ADDR_CFG, 32'h10, 4'he, r);
    tick(3);
    check("partial write", 5'h00, irq_req);
    cfg(8'h10);
    tick(3);
    check("gen on", 5'h10, irq_req);
    status(32'h110, "status req");
    axi_rd(`IWC_ADDR_CFG, d, r);
    check("cfg hidden", 32'h0, d);
    cfg(8'h00);
    tick(3);
    check("gen off", 5'h00, irq_req);
    set_periph(12'h000);
    $display("test regs done");
  endtask
  task automatic t_vectors;
    logic [11:0] f;
    logic [4:0] e;
    cfg(8'h10);
    for (int k = 0; k < 6; k++) begin
      f = 12'h800 >> (2 * k);
      e = (k < 2) ? 5'h10 : (k < 5) ? 5'h08 : 5'h04;
      set_periph(f);
      tick(3);
      check("unmasked off", 5'h00, irq_req);
      set_periph(f | (f >> 1));
      tick(3);
      check("vector map", e, irq_req);
    end
    set_periph(12'h000);
    $display("test vectors done");
  endtask
  task automatic t_pins;
    pins(8'hfe, 8'hff, 8'hff, 1'b1);
    tick(4);
    check("port a fall", 5'h02, irq_req);
    pins(8'hff, 8'hff, 8'hff, 1'b1);
    tick(4);
    pins(8'hfe, 8'hff, 8'hff, 1'b1);
    tick(4);
    pins(8'hff, 8'hff, 8'hff, 1'b1);
    tick(4);
    check("port a held", 5'h02, irq_req);
    ack();
    check("port a once", 5'h00, irq_req);
    cfg(8'h50);
    pins(8'hff, 8'hfd, 8'hff, 1'b1);
    tick(4);
    check("level low", 5'h02, irq_req);
    pins(8'hff, 8'hff, 8'hff, 1'b1);
    tick(4);
    check("level gone", 5'h00, irq_req);
    @(posedge clk_sys);
    port_b_cfg <= 24'h000202;
    pins(8'hff, 8'hfd, 8'hff, 1'b1);
    tick(4);
    check("pin disabled", 5'h00, irq_req);
    @(posedge clk_sys);
    port_b_cfg <= 24'h000200;
    cfg(8'h30);
    pins(8'hff, 8'hff, 8'hfb, 1'b1);
    tick(4);
    check("c fall in rise", 5'h00, irq_req);
    pins(8'hff, 8'hff, 8'hff, 1'b1);
    tick(4);
    check("c rise", 5'h04, irq_req);
    ack();
    cfg(8'h10);
    pins(8'hff, 8'hff, 8'hfb, 1'b1);
    tick(4);
    check("c fall", 5'h04, irq_req);
    pins(8'hff, 8'hff, 8'hff, 1'b1);
    ack();
    $display("test pins done");
  endtask
  // stop wakes from a pin or the nmi line; wait wakes from the timer
  task automatic sleep(input logic stop, input iwc_mode_t m, input logic nmi,
      input logic svc);
    int n;
    @(posedge clk_sys);
    core_mode <= m;
    cmd(stop);
    check("halted", 1'b1, core_halt);
    check("osc stop", stop, osc_stop);
    if (stop) begin
      set_periph(12'hc00);
      tick(6);
      check("timer no wake", 1'b1, core_halt);
      pins(nmi ? 8'hff : 8'hfe, 8'hff, 8'hff, !nmi);
    end else begin
      set_periph(12'hc00);
    end
    wait_pulse(1'b0, n);
    if (stop) check("stab delay", 1'b1, n >= STAB && n < 60);
    else check("no delay", 1'b1, n <= 3);
    check("service", svc, wake_service);
    tick(1);
    check("resumed", 1'b0, core_halt);
    check("osc running", 1'b0, osc_stop);
    set_periph(12'h000);
    pins(8'hff, 8'hff, 8'hff, 1'b1);
    @(posedge clk_sys);
    core_mode <= IWC_MODE_NORMAL;
    tick(4);
    ack();
    $display("test sleep done");
  endtask
  task automatic t_misc;
    int n;
    set_periph(12'hc00);
    tick(3);
    cmd(1'b0);
    wait_pulse(1'b1, n);
    check("skip seen", 1'b1, n < 3);
    check("not halted", 1'b0, core_halt);
    set_periph(12'h000);
    @(posedge clk_sys);
    watchdog_active <= 1'b1;
    cmd(1'b1);
    check("wd osc runs", 1'b0, osc_stop);
    set_periph(12'hc00);
    wait_pulse(1'b0, n);
    check("wd fast wake", 1'b1, n <= 3);
    set_periph(12'h000);
    @(posedge clk_sys);
    watchdog_active <= 1'b0;
    cfg(8'h00);
    cmd(1'b1);
    pins(8'hff, 8'hff, 8'hff, 1'b0);
    tick(STAB + 10);
    check("nmi no wake", 1'b1, core_halt);
    check("nmi request", 5'h01, irq_req);
    pins(8'hff, 8'hff, 8'hff, 1'b1);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    tick(2);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(3);
    check("reset halt", 1'b0, core_halt);
    check("reset osc", 1'b0, osc_stop);
    status(32'h100, "status after reset");
    $display("test misc done");
  endtask

  // ---------------------------------
  // run control
  // ---------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    tick(3);
    t_regs;
    t_vectors;
    t_pins;
    sleep(1'b0, IWC_MODE_NORMAL, 1'b0, 1'b1);
    sleep(1'b1, IWC_MODE_NORMAL, 1'b0, 1'b1);
    sleep(1'b1, IWC_MODE_NMI, 1'b0, 1'b0);
    sleep(1'b1, IWC_MODE_IRQ, 1'b0, 1'b0);
    sleep(1'b1, IWC_MODE_IRQ, 1'b1, 1'b1);
    t_misc;
    wrap_up;
  end
  // whole run needs a few hundred cycles; this is far past it
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    $display("ERROR watchdog expected done seen timeout");
    wrap_up;
  end
endmodule
